// File: sap_ctrl.sv
`timescale 1ns/100ps

module sap_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,       // Clock
	input  wire logic             rst_b_i,     // Sync reset, low
	input  wire logic             in_valid_i,  // Write request
	input  wire logic [WIDTH-1:0] in_data_i,   // Write data
	output logic                  in_ready_o,  // Not full
	output logic                  out_valid_o, // Not empty
	output logic      [WIDTH-1:0] out_data_o,  // Head word
	input  wire logic             out_ready_i  // Pop request
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;
	logic             full;
	logic             empty;

	// Extra pointer bit tells full from empty
	assign full        = (wr_ptr[AW] != rd_ptr[AW]) &&
		(wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty       = (wr_ptr == rd_ptr);
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = mem[rd_ptr[AW-1:0]];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_ready_i && out_valid_o;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			wr_ptr <= '0;
		end else if (push) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

module sap_ctrl #(
	parameter int RES_BITS = sap_pkg::RES_BITS_DFLT
) (
	input  wire logic                 ref_clk_i,       // System clock
	input  wire logic                 rst_b_i,         // Reset, low; sync on ref_clk_i, async for take_tgl and cap
	input  wire logic                 sclk_i,          // Serial link clock
	input  wire logic                 cs_n_i,          // Chip select, low
	input  wire logic                 sample_valid_i,  // Result offered
	input  wire logic [RES_BITS-1:0]  sample_i,        // Result word
	output logic                      sample_ready_o,  // FIFO accepts
	output logic                      serial_out_o,    // Serial data
	output logic                      serial_out_oe_o, // Serial drive
	output logic                      hold_o,          // Sample held
	output sap_pkg::sap_status_t      status_o,        // Mode status
	output logic [sap_pkg::CNT_W-1:0] edges_o,         // Last frame edges
	output logic                      frame_end_o      // Frame ended
);
	import sap_pkg::*;

	localparam int TRAIL = FRAME_BITS - LEAD_ZEROS - RES_BITS;
	localparam logic [CNT_W-1:0] EDGE_TRACK = CNT_W'(RES_BITS + 1);

	// Link side, falling sclk edges and select rise; cnt and sreg cleared while select is high
	logic [CNT_W-1:0]      cnt;
	logic [CNT_W-1:0]      next_cnt;
	logic [FRAME_BITS-1:0] sreg;
	logic [FRAME_BITS-1:0] next_sreg;
	logic                  take_tgl;
	logic                  next_take_tgl;
	sap_cap_t              cap;
	sap_cap_t              next_cap;

	// System side
	logic [RES_BITS-1:0] shadow;
	logic                shadow_full;
	logic                fifo_valid;
	logic [RES_BITS-1:0] fifo_data;
	logic                load;
	logic [1:0]          cs_sync;
	logic [1:0]          cap_sync;
	logic                cap_seen;
	logic [1:0]          take_sync;
	logic                take_seen;
	logic                cap_evt;
	logic                take_evt;
	sap_mode_t           mode;
	sap_mode_t           next_mode;
	sap_status_t         next_status;
	logic                next_shadow_full;
	logic [RES_BITS-1:0] next_shadow;

	// Saturates at the last edge; later edges ignored
	always_comb begin
		next_cnt = cnt;
		if (cnt != EDGE_LAST) begin
			next_cnt = cnt + 1'b1;
		end
	end

	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			cnt <= EDGE_ZERO;
		end else begin
			cnt <= next_cnt;
		end
	end

	// Second lead zero, word, trailing zeros
	always_comb begin
		next_sreg = {sreg[FRAME_BITS-2:0], 1'b0};
		if (cnt == EDGE_ZERO) begin
			next_sreg = {1'b0, shadow, {TRAIL{1'b0}}, 1'b0};
		end
	end

	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			sreg <= '0;
		end else begin
			sreg <= next_sreg;
		end
	end

	// Word taken at the first edge of every frame
	always_comb begin
		next_take_tgl = take_tgl;
		if (!cs_n_i && cnt == EDGE_ZERO) begin
			next_take_tgl = ~take_tgl;
		end
	end

	always_ff @(negedge sclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			take_tgl <= 1'b0;
		end else begin
			take_tgl <= next_take_tgl;
		end
	end

	// Edge count frozen at the select rise; cnt clears after this edge
	always_comb begin
		next_cap.edges = cnt;
		next_cap.tgl   = ~cap.tgl;
	end

	always_ff @(posedge cs_n_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cap <= '0;
		end else begin
			cap <= next_cap;
		end
	end

	// Output bit and drive for the link
	assign serial_out_o    = sreg[FRAME_BITS-1];
	assign serial_out_oe_o = !cs_n_i && (cnt != EDGE_LAST);
	assign hold_o          = !cs_n_i && (cnt <= EDGE_TRACK);

	// Two-flop synchronisers into the system clock
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			cs_sync <= 2'h3;
		end else begin
			cs_sync <= {cs_sync[0], cs_n_i};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			cap_sync <= 2'h0;
		end else begin
			cap_sync <= {cap_sync[0], cap.tgl};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			take_sync <= 2'h0;
		end else begin
			take_sync <= {take_sync[0], take_tgl};
		end
	end

	assign cap_evt  = cap_sync[1] != cap_seen;
	assign take_evt = take_sync[1] != take_seen;

	// Seen copies turn toggles into one-cycle events
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			cap_seen <= 1'b0;
		end else begin
			cap_seen <= cap_sync[1];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			take_seen <= 1'b0;
		end else begin
			take_seen <= take_sync[1];
		end
	end

	// Next mode from the edge count of the finished frame
	always_comb begin
		next_mode = mode;
		unique case (mode)
			SAP_NORMAL: begin
				if (cap.edges >= EDGE_GLITCH && cap.edges < EDGE_AWAKE) begin
					next_mode = SAP_PARTIAL;
				end
			end
			SAP_PARTIAL: begin
				if (cap.edges >= EDGE_AWAKE) begin
					next_mode = SAP_NORMAL;
				end else begin
					next_mode = SAP_FULL;
				end
			end
			SAP_FULL: begin
				if (cap.edges >= EDGE_AWAKE) begin
					next_mode = SAP_NORMAL;
				end else begin
					next_mode = SAP_FULL;
				end
			end
			default: begin
				next_mode = SAP_FULL;
			end
		endcase
	end

	// Mode moves once per select rise
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			mode <= MODE_RST;
		end else if (cap_evt) begin
			mode <= next_mode;
		end
	end

	// Count of the finished frame, held until the next
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			edges_o <= EDGE_ZERO;
		end else if (cap_evt) begin
			edges_o <= cap.edges;
		end
	end

	// One pulse per select rise
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			frame_end_o <= 1'b0;
		end else begin
			frame_end_o <= cap_evt;
		end
	end

	// Analog powers up from select fall while powered down
	always_comb begin
		next_status.mode      = mode;
		next_status.analog_on = (mode == SAP_NORMAL) || !cs_sync[1];
		next_status.powered   = (mode == SAP_NORMAL);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			status_o <= '{mode: MODE_RST, analog_on: 1'b1, powered: 1'b1};
		end else begin
			status_o <= next_status;
		end
	end

	// Shadow reloads only while select idles high, so the link sees a
	// stable word; a dummy frame in power-down keeps the word pending
	assign load = !shadow_full && fifo_valid && cs_sync[1];

	// Full until a frame in normal mode takes the word
	always_comb begin
		next_shadow_full = shadow_full;
		if (load) begin
			next_shadow_full = 1'b1;
		end else if (take_evt && mode == SAP_NORMAL) begin
			next_shadow_full = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			shadow_full <= 1'b0;
		end else begin
			shadow_full <= next_shadow_full;
		end
	end

	// Next shadow word from the FIFO head
	always_comb begin
		next_shadow = shadow;
		if (load) begin
			next_shadow = fifo_data;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			shadow <= '0;
		end else begin
			shadow <= next_shadow;
		end
	end

	// Pop is the shadow load
	sap_fifo #(
		.WIDTH (RES_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (ref_clk_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (sample_valid_i),
		.in_data_i   (sample_i),
		.in_ready_o  (sample_ready_o),
		.out_valid_o (fifo_valid),
		.out_data_o  (fifo_data),
		.out_ready_i (load)
	);
endmodule

// File: sap_pkg.sv
package sap_pkg;
	localparam int RES_BITS_DFLT = 12;
	localparam int FRAME_BITS    = 16;
	localparam int LEAD_ZEROS    = 2;
	localparam int FIFO_DEPTH    = 16;
	localparam int CNT_W         = 5;

	localparam logic [CNT_W-1:0] EDGE_GLITCH = 5'h02;
	localparam logic [CNT_W-1:0] EDGE_AWAKE  = 5'h0A;
	localparam logic [CNT_W-1:0] EDGE_LAST   = 5'h10;
	localparam logic [CNT_W-1:0] EDGE_ZERO   = 5'h00;

	typedef enum logic [1:0] {
		SAP_NORMAL  = 2'b00,
		SAP_PARTIAL = 2'b01,
		SAP_FULL    = 2'b11
	} sap_mode_t;

	localparam sap_mode_t MODE_RST = SAP_NORMAL;

	typedef struct packed {
		sap_mode_t mode;
		logic      analog_on;
		logic      powered;
	} sap_status_t;

	typedef struct packed {
		logic [CNT_W-1:0] edges;
		logic             tgl;
	} sap_cap_t;
endpackage

// File: sap_ctrl_chk.sv
`timescale 1ns/100ps
module sap_ctrl_chk
	import sap_pkg::*;
#(
	parameter int RES_BITS = 12
) (
	input wire logic        ref_clk_i,       // Clock
	input wire logic        rst_b_i,         // Reset
	input wire logic        sclk_i,          // Link clock
	input wire logic        cs_n_i,          // Select
	input wire logic        serial_out_oe_o, // Drive
	input wire logic        hold_o,          // Hold
	input wire sap_status_t status_o,        // Status
	input wire logic [4:0]  edges_o,         // Edges
	input wire logic        frame_end_o      // Frame end
);
	logic [4:0] cnt;
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i)
			cnt <= EDGE_ZERO;
		else if (cnt != EDGE_LAST)
			cnt <= cnt + 5'h01;
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	oe_gate_a: assert property (
		serial_out_oe_o == (!cs_n_i && cnt != EDGE_LAST))
		else $error("drive wrong");
	hold_a: assert property (
		hold_o == (!cs_n_i && cnt <= RES_BITS + 1))
		else $error("hold wrong");
	part_in_a: assert property (
		frame_end_o && status_o.mode == SAP_NORMAL
		&& edges_o inside {[EDGE_GLITCH:EDGE_AWAKE - 5'h01]}
		|=> status_o.mode == SAP_PARTIAL)
		else $error("partial wrong");
	stay_on_a: assert property (
		frame_end_o && status_o.mode == SAP_NORMAL
		&& !(edges_o inside {[EDGE_GLITCH:EDGE_AWAKE - 5'h01]})
		|=> status_o.mode == SAP_NORMAL)
		else $error("normal lost");
	full_in_a: assert property (
		frame_end_o && status_o.mode != SAP_NORMAL
		&& edges_o < EDGE_AWAKE |=> status_o.mode == SAP_FULL)
		else $error("full wrong");
	wake_up_a: assert property (
		frame_end_o && status_o.mode != SAP_NORMAL
		&& edges_o >= EDGE_AWAKE |=> status_o.mode == SAP_NORMAL)
		else $error("wake wrong");
	mode_hold_a: assert property (
		!$past(frame_end_o) |-> $stable(status_o.mode))
		else $error("mode moved");
	end_pulse_a: assert property (
		$rose(cs_n_i) |-> ##[1:8] frame_end_o)
		else $error("no frame end");
endmodule

// File: sap_host.sv
`timescale 1ns/100ps
module sap_host (
	input  wire logic ref_clk_i, // Clock
	input  wire logic so_i,      // Serial data
	input  wire logic oe_i,      // Serial drive
	output logic      sclk_o,    // Link clock
	output logic      cs_n_o     // Select
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b0;
		#1 cs_n_o = 1'b1;
	end
	task automatic run(input int n, input bit wk, output logic [15:0] rx);
		rx = '0;
		@(posedge ref_clk_i) #2 cs_n_o = 1'b0;
		if (wk)
			#1000;
		repeat (n) begin
			#6 sclk_o = 1'b1;
			rx = {rx[14:0], oe_i ? so_i : 1'bz};
			#6 sclk_o = 1'b0;
		end
		@(posedge ref_clk_i) #2 cs_n_o = 1'b1;
		repeat (6) @(posedge ref_clk_i);
	endtask
endmodule

// File: tb_sap_ctrl.sv
`timescale 1ns/100ps
module tb_sap_ctrl;
	import sap_pkg::*;
	localparam int RB = 12;
	logic          clk, rst_b, sclk, cs_n, vld, rdy, so, oe, hold, fe;
	logic [RB-1:0] smp;
	logic [4:0]    edg;
	logic [15:0]   rx;
	sap_status_t   st;
	sap_mode_t     md;
	int            error_cnt, compares, idx;
	sap_ctrl #(.RES_BITS(RB)) dut (.ref_clk_i(clk), .rst_b_i(rst_b),
		.sclk_i(sclk), .cs_n_i(cs_n), .sample_valid_i(vld), .sample_i(smp),
		.sample_ready_o(rdy), .serial_out_o(so), .serial_out_oe_o(oe),
		.hold_o(hold), .status_o(st), .edges_o(edg), .frame_end_o(fe));
	sap_host host (.ref_clk_i(clk), .so_i(so), .oe_i(oe), .sclk_o(sclk),
		.cs_n_o(cs_n));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	function automatic logic [RB-1:0] wd(input int i);
		return RB'(12'hA53 + 12'(i) * 12'h10F);
	endfunction
	task automatic frame(input int n, bit wk, sap_mode_t m, bit chk);
		host.run(n, wk, rx);
		if (chk)
			cmp(rx, {2'b00, wd(idx), {(14-RB){1'b0}}} >> (16 - n));
		cmp(16'(st), 16'({m, m == SAP_NORMAL, m == SAP_NORMAL}));
		cmp(16'(edg), 16'(n));
		if (md == SAP_NORMAL && n > 0)
			idx++;
		md = m;
	endtask
	task automatic t_fill;
		int k;
		k = 0;
		while (rdy === 1'b1 && k < 40) begin
			smp = wd(k);
			vld = 1'b1;
			@(posedge clk) #2;
			k++;
		end
		vld = 1'b0;
		cmp(16'(k), 16'h0011);
	endtask
	task automatic t_normal;
		frame(16, 0, SAP_NORMAL, 1);
		frame(16, 0, SAP_NORMAL, 1);
		frame(12, 0, SAP_NORMAL, 1);
	endtask
	task automatic t_glitch;
		frame(1, 0, SAP_NORMAL, 1);
	endtask
	task automatic t_partial;
		frame(5, 0, SAP_PARTIAL, 1);
		frame(16, 0, SAP_NORMAL, 0);
		frame(16, 0, SAP_NORMAL, 1);
	endtask
	task automatic t_full;
		frame(3, 0, SAP_PARTIAL, 1);
		frame(9, 0, SAP_FULL, 0);
		frame(16, 1, SAP_NORMAL, 0);
		frame(16, 0, SAP_NORMAL, 1);
	endtask
	task automatic t_drain;
		while (idx < 17)
			frame(16, 0, SAP_NORMAL, 1);
		cmp(16'(rdy), 16'h0001);
	endtask
	task automatic end_sim;
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		error_cnt = 0;
		compares = 0;
		idx = 0;
		md = SAP_NORMAL;
		rst_b = 1'b0;
		vld = 1'b0;
		smp = '0;
		repeat (16) @(posedge clk);
		#2 rst_b = 1'b1;
		t_fill;
		t_normal;
		t_glitch;
		t_partial;
		t_full;
		t_drain;
		end_sim;
	end
endmodule
bind sap_ctrl sap_ctrl_chk #(.RES_BITS(RES_BITS)) chk (
	.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk_i),
	.cs_n_i(cs_n_i), .serial_out_oe_o(serial_out_oe_o), .hold_o(hold_o),
	.status_o(status_o), .edges_o(edges_o), .frame_end_o(frame_end_o));
